// ==== src/mta_edge.sv ====
// one-cycle pulses on rising and on falling level changes of an enable input
`timescale 1ns/1ps
`default_nettype none
module mta_edge
    import mta_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic level_in,
    output logic rise_pulse,
    output logic fall_pulse
);
    logic prev_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level_in;
        end
    end

    assign rise_pulse = level_in & ~prev_r;
    assign fall_pulse = ~level_in & prev_r;
endmodule
`default_nettype wire

// ==== src/mta_pkg.sv ====
// package: modes, selections and constants of the timer channel
package mta_pkg;
    localparam int MTA_WIDTH = 16;
    localparam logic [15:0] MTA_RESET_COUNT = 16'h0000;
    localparam logic [15:0] MTA_COUNT_MAX = 16'hffff;
    localparam logic [15:0] MTA_COUNT_MIN = 16'h0000;
    localparam int MTA_SYNC_STAGES = 2;
    localparam int MTA_SINGLE_PHASE_ONLY_CHANNELS = 2;

    // operating mode, bits 0 and 1 of the mode field
    localparam logic [1:0] MTA_MODE_TIMER = 2'h0;
    localparam logic [1:0] MTA_MODE_EVENT = 2'h1;
    localparam logic [1:0] MTA_MODE_ONESHOT = 2'h2;
    localparam logic [1:0] MTA_MODE_PWM = 2'h3;

    // timer mode count source
    localparam logic [1:0] MTA_SRC_F1 = 2'h0;
    localparam logic [1:0] MTA_SRC_F8 = 2'h1;
    localparam logic [1:0] MTA_SRC_F32 = 2'h2;
    localparam logic [1:0] MTA_SRC_SUBCLOCK_DIV32_CLOCK = 2'h3;

    // event mode count source
    localparam logic [1:0] MTA_EVT_PIN = 2'h0;
    localparam logic [1:0] MTA_EVT_B2 = 2'h1;
    localparam logic [1:0] MTA_EVT_NEIGH = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] timer_src;
        logic [1:0] event_src;
        logic gate_en;
        logic gate_level;
        logic pulse_en;
        logic edge_rising;
        logic dir_ext;
        logic dir_up;
        logic free_run;
    } mta_cfg_t;

    typedef struct packed {
        logic wr;
        logic [15:0] wdata;
    } mta_wr_t;
endpackage

// ==== src/mta_sync.sv ====
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module mta_sync
    import mta_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    initial begin
        if (WIDTH < 1) begin
            $error("mta_sync width must be at least one");
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule
`default_nettype wire

// ==== src/mta_timer.sv ====
// one 16-bit timer channel, timer and event counter modes
//
// Notes on behaviour
// - timer mode counts one selected internal tick: f1, div8, div32, sub div32.
// - timer mode decrements per tick; underflow reloads and keeps counting.
// - underflow rate equals tick rate over programmed value plus one.
// - counting runs while the start flag is one, halts when zero.
// - timer mode raises the interrupt request on each underflow.
// - write while stopped stores into reload register and counter.
// - write while running changes only reload; counter takes it at reload.
// - reading the count returns the live counter, not the reload value.
// - gate enabled: input pin level starts and stops timer counting.
// - timer mode pulse output inverts output pin on every underflow.
// - timer mode input pin is port or gate; output pin port or pulse.
// - event mode counts pin edges, B-group overflow or neighbour overflow.
// - event direction from software or from external level on output pin.
// - event mode without free-run reloads on overflow and underflow.
// - event ratio is 1/(FFFF-n+1) counting up, 1/(n+1) counting down.
// - event mode raises the interrupt request on overflow and underflow.
// - free-run wraps on overflow or underflow without reloading.
// - event mode pulse output inverts output pin on each wrap.
// - event mode output pin is port, pulse output or direction input.
// - event mode input pin is port or external count source.
// - channels zero and one count single-phase only; two-phase not built.
// - mode field bits zero and one pick timer or event; one-shot and pwm codes hold the counter.
// - counter and reload are 16 bits; channels work independently.
`timescale 1ns/1ps
`default_nettype none
module mta_timer
    import mta_pkg::*;
#(
    parameter int CHANNEL = 0,
    parameter int WIDTH = MTA_WIDTH
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire mta_cfg_t cfg,
    input wire logic start_flag,
    input wire mta_wr_t count_wr,
    output logic [WIDTH-1:0] count_rd,
    input wire logic tick_f1,
    input wire logic tick_f8,
    input wire logic tick_f32,
    input wire logic tick_subclock_div32_clock,
    input wire logic second_b_group_timer_ovf,
    input wire logic neighbour_a_group_timer_ovf,
    input wire logic timer_input_pin_in,
    input wire logic timer_output_pin_in,
    output logic timer_output_pin_out,
    output logic timer_output_pin_oe,
    output logic port_out,
    input wire logic port_oe,
    output logic port_in_value,
    output logic port_out_in_value,
    output logic irq_pulse,
    output logic [WIDTH-1:0] reload_value
);
    // ****************************************
    // elaboration checks
    // ****************************************
    initial begin
        if (WIDTH != MTA_WIDTH) begin
            $error("mta_timer supports only the 16-bit counter");
        end
        if (CHANNEL < 0 || CHANNEL > 4) begin
            $error("mta_timer channel must be 0 to 4");
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [2:0] pin_raw;
    logic [2:0] pin_sync;
    logic in_sync;
    logic dir_pin_sync;

    assign pin_raw = {timer_output_pin_in, timer_input_pin_in, 1'b0};

    mta_sync #(
        .WIDTH(3)
    ) u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .async_in(pin_raw),
        .sync_out(pin_sync)
    );

    assign in_sync = pin_sync[1];
    assign dir_pin_sync = pin_sync[2];
    assign port_in_value = in_sync;
    assign port_out_in_value = dir_pin_sync;

    logic in_rise;
    logic in_fall;

    mta_edge u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .level_in(in_sync),
        .rise_pulse(in_rise),
        .fall_pulse(in_fall)
    );

    // ****************************************
    // mode and source decode
    // ****************************************
    logic mode_timer;
    logic mode_event;
    logic timer_tick;
    logic gate_open;
    logic event_tick;
    logic pin_edge;
    logic count_up;
    logic running;
    logic step;

    assign mode_timer = (cfg.mode == MTA_MODE_TIMER);
    assign mode_event = (cfg.mode == MTA_MODE_EVENT);

    assign timer_tick = (cfg.timer_src == MTA_SRC_F1) ? tick_f1 :
                        (cfg.timer_src == MTA_SRC_F8) ? tick_f8 :
                        (cfg.timer_src == MTA_SRC_F32) ? tick_f32 :
                        tick_subclock_div32_clock;

    assign gate_open = !cfg.gate_en || (in_sync == cfg.gate_level);

    assign pin_edge = cfg.edge_rising ? in_rise : in_fall;

    assign event_tick = (cfg.event_src == MTA_EVT_PIN) ? pin_edge :
                        (cfg.event_src == MTA_EVT_B2) ? second_b_group_timer_ovf :
                        (cfg.event_src == MTA_EVT_NEIGH) ? neighbour_a_group_timer_ovf :
                        1'b0;

    assign count_up = cfg.dir_ext ? dir_pin_sync : cfg.dir_up;

    assign running = start_flag;

    assign step = running && ((mode_timer && timer_tick && gate_open)
                              || (mode_event && event_tick));

    // ****************************************
    // counter and reload register
    // ****************************************
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic [WIDTH-1:0] reload_r;
    logic [WIDTH-1:0] reload_nxt;
    logic wrap_dn;
    logic wrap_up;
    logic wrap;
    logic do_reload;
    logic [WIDTH-1:0] stepped;

    assign wrap_dn = step && (mode_timer || !count_up) && (cnt_r == MTA_COUNT_MIN);
    assign wrap_up = step && mode_event && count_up && (cnt_r == MTA_COUNT_MAX);
    assign wrap = wrap_dn || wrap_up;

    assign do_reload = wrap && (mode_timer || !cfg.free_run);

    assign stepped = (mode_event && count_up) ? cnt_r + 16'h0001
                                              : cnt_r - 16'h0001;

    assign reload_nxt = count_wr.wr ? count_wr.wdata : reload_r;

    always_comb begin
        cnt_nxt = cnt_r;
        if (count_wr.wr && !running) begin
            cnt_nxt = count_wr.wdata;
        end else if (do_reload) begin
            cnt_nxt = reload_nxt;
        end else if (step) begin
            cnt_nxt = stepped;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= MTA_RESET_COUNT;
            reload_r <= MTA_RESET_COUNT;
        end else begin
            cnt_r <= cnt_nxt;
            reload_r <= reload_nxt;
        end
    end

    assign count_rd = cnt_r;
    assign reload_value = reload_r;

    // ****************************************
    // interrupt request and pulse output
    // ****************************************
    logic irq_r;
    logic pulse_r;
    logic pulse_active;
    logic dir_input_mode;

    assign pulse_active = cfg.pulse_en && (mode_timer || mode_event);
    assign dir_input_mode = mode_event && cfg.dir_ext;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_r <= 1'b0;
            pulse_r <= 1'b0;
        end else begin
            irq_r <= wrap;
            if (!pulse_active) begin
                pulse_r <= 1'b0;
            end else if (wrap) begin
                pulse_r <= ~pulse_r;
            end
        end
    end

    assign irq_pulse = irq_r;
    assign port_out = 1'b0;
    assign timer_output_pin_out = pulse_active ? pulse_r : 1'b0;
    assign timer_output_pin_oe = pulse_active && !dir_input_mode;

    // ****************************************
    // checks
    // ****************************************
    sequence s_stopped_write;
        count_wr.wr && !running;
    endsequence

    sequence s_down_wrap;
        step && mode_timer && cnt_r == 16'h0000;
    endsequence

    chk_stopped_write_load: assert property (@(posedge mclk) disable iff (!rst_n)
        s_stopped_write |=> (cnt_r == $past(count_wr.wdata)
                             && reload_r == $past(count_wr.wdata)))
        else $error("stopped write did not load counter and reload");

    chk_running_write_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        count_wr.wr && running && !step |=> cnt_r == $past(cnt_r))
        else $error("running write changed counter");

    chk_timer_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        s_down_wrap |=> cnt_r == $past(reload_nxt))
        else $error("timer underflow did not reload");

    chk_timer_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        s_down_wrap |=> irq_pulse)
        else $error("no interrupt on timer underflow");

    chk_event_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap_up |=> irq_pulse)
        else $error("no interrupt on overflow");

    chk_stop_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !running && !count_wr.wr |=> cnt_r == $past(cnt_r))
        else $error("counter moved while stopped");

    chk_gate_closed: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_timer && !gate_open && !count_wr.wr |=> cnt_r == $past(cnt_r))
        else $error("counter moved with gate closed");

    chk_pulse_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap && pulse_active && $stable(cfg) |=> pulse_r != $past(pulse_r))
        else $error("pulse output did not toggle");

    chk_free_run_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap_up && cfg.free_run && !count_wr.wr |=> cnt_r == 16'h0000)
        else $error("free-run overflow did not wrap to zero");

    chk_up_step: assert property (@(posedge mclk) disable iff (!rst_n)
        step && mode_event && count_up && !wrap && !(count_wr.wr && !running)
        |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("up count step wrong");

    // ****************************************
    // event mode and output checks
    // ****************************************
    sequence s_event_down_reload;
        step && mode_event && !count_up && !cfg.free_run && cnt_r == 16'h0000;
    endsequence

    sequence s_event_down_free;
        step && mode_event && !count_up && cfg.free_run && cnt_r == 16'h0000;
    endsequence

    chk_event_down_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        s_event_down_reload |=> cnt_r == $past(reload_nxt))
        else $error("event underflow did not reload");

    chk_event_up_reload: assert property (@(posedge mclk) disable iff (!rst_n)
        wrap_up && !cfg.free_run |=> cnt_r == $past(reload_nxt))
        else $error("event overflow did not reload");

    chk_free_run_down: assert property (@(posedge mclk) disable iff (!rst_n)
        s_event_down_free |=> cnt_r == 16'hffff)
        else $error("free-run underflow did not wrap to all ones");

    chk_down_step: assert property (@(posedge mclk) disable iff (!rst_n)
        step && !wrap && (mode_timer || !count_up)
        |=> cnt_r == $past(cnt_r) - 16'h0001)
        else $error("down count step wrong");

    chk_irq_only_wrap: assert property (@(posedge mclk) disable iff (!rst_n)
        irq_pulse |-> $past(wrap))
        else $error("interrupt without a wrap");

    chk_dir_input_oe: assert property (@(posedge mclk) disable iff (!rst_n)
        dir_input_mode |-> !timer_output_pin_oe)
        else $error("output pin driven in direction input mode");

    chk_pulse_off_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !pulse_active |-> !timer_output_pin_out)
        else $error("pulse output driven while off");

    chk_idle_mode_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        !mode_timer && !mode_event && !count_wr.wr |=> cnt_r == $past(cnt_r))
        else $error("counter moved in an unbuilt mode");
endmodule
`default_nettype wire

// ==== tb/mta_pin_model.sv ====
// pin-side partner: gate level, count pulses, direction level
`timescale 1ns/1ps
`default_nettype none
module mta_pin_model (
    input wire logic mclk,
    input wire logic gate,
    input wire logic fire,
    input wire logic dir,
    input wire logic dir_drive,
    output logic in_pin,
    output logic out_pin
);
    logic [2:0] pulse_r = 3'h0;
    logic alt_r = 1'b0;
    logic take_r = 1'b0;
    // ****************
    // pin drive
    // ****************
    always @(posedge mclk) begin
        take_r = fire;
        #2;
        pulse_r = take_r ? 3'h4 : (pulse_r != 3'h0 ? pulse_r - 3'h1 : 3'h0);
        alt_r = ~alt_r;
    end
    assign in_pin = gate | (pulse_r != 3'h0);
    // released line toggles every cycle
    assign out_pin = dir_drive ? dir : alt_r;
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking testbench for the timer channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mta_pkg::*;
    logic mclk = 0, rst_n = 0, start = 0, g = 0, d = 0, dd = 0, fire = 0, b2 = 0, nb = 0;
    logic [3:0] tk = 4'h0;
    mta_cfg_t cfg = '0;
    mta_wr_t wr = '0;
    logic [15:0] cnt_o, rl_o, m_cnt, m_rl;
    logic pin_o, oe_o, irq, ip, op, pin_e = 1'b0;
    logic [31:0] seed = 32'hc5b9;
    logic [16:0] q[$];
    logic [16:0] e;
    int fails = 0, n_tests = 0;
    mta_timer mta_timer_i(.mclk, .rst_n, .cfg, .start_flag(start), .count_wr(wr),
        .count_rd(cnt_o), .tick_f1(tk[0]), .tick_f8(tk[1]), .tick_f32(tk[2]),
        .tick_subclock_div32_clock(tk[3]), .second_b_group_timer_ovf(b2),
        .neighbour_a_group_timer_ovf(nb), .timer_input_pin_in(ip),
        .timer_output_pin_in(op), .timer_output_pin_out(pin_o),
        .timer_output_pin_oe(oe_o), .port_out(), .port_oe(1'b0), .port_in_value(),
        .port_out_in_value(), .irq_pulse(irq), .reload_value(rl_o));
    mta_pin_model mta_pin_model_i(.mclk, .gate(g), .fire, .dir(d), .dir_drive(dd),
        .in_pin(ip), .out_pin(op));
    // ****************
    // helpers
    // ****************
    initial forever #25 mclk = ~mclk;
    task automatic cyc(int n);
        repeat (n) begin
            @(posedge mclk);
            #2;
        end
    endtask
    task automatic rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endtask
    task automatic chk(logic [16:0] got, logic [16:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic final_report();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // model step, notes a wrap in the queue
    task automatic step(logic up, logic fr);
        if (m_cnt == (up ? 16'hffff : 16'h0000)) begin
            m_cnt = fr ? ~m_cnt : m_rl;
            pin_e = ~pin_e;
            q.push_back({pin_e, m_cnt});
        end else begin
            m_cnt = up ? m_cnt + 16'h0001 : m_cnt - 16'h0001;
        end
    endtask
    task automatic load(logic [15:0] v);
        wr = '{1'b1, v};
        cyc(1);
        wr.wr = 1'b0;
        m_rl = v;
        if (!start)
            m_cnt = v;
        cyc(1);
    endtask
    // selected tick plus random ticks on the others
    task automatic tick(int s, logic run);
        rnd();
        tk = (4'h1 << s) | (seed[3:0] & ~(4'h1 << s));
        cyc(1);
        tk = 4'h0;
        if (run)
            step(1'b0, 1'b0);
        cyc(3);
    endtask
    task automatic ev(int s, logic up, logic fr);
        fire = (s == 0);
        b2 = (s == 1);
        nb = (s == 2);
        cyc(1);
        {fire, b2, nb} = 3'h0;
        step(up, fr);
        cyc(10);
    endtask
    // ****************
    // result monitor
    // ****************
    always @(negedge mclk) begin
        if (irq === 1'b1) begin
            e = q.size() > 0 ? q.pop_front() : 17'h1dead;
            chk({pin_o, cnt_o}, e);
        end
    end
    initial begin
        #2000000;
        fails++;
        final_report();
    end
    // ****************
    // tests
    // ****************
    initial begin
        cyc(6);
        rst_n = 1'b1;
        cfg.mode = MTA_MODE_TIMER;
        cfg.pulse_en = 1'b1;
        for (int s = 0; s < 4; s++) begin
            cfg.timer_src = 2'(s);
            rnd();
            load({14'h0, seed[1:0]} + 16'h0001);
            chk({1'b0, cnt_o}, {1'b0, m_cnt});
            start = 1'b1;
            for (int i = 0; i < 2 * (m_rl + 1); i++) tick(s, 1'b1);
            load(16'h0003);
            chk({1'b0, rl_o}, 17'h00003);
            chk({1'b0, cnt_o}, {1'b0, m_cnt});
            for (int i = 0; i < 9; i++) tick(s, 1'b1);
            start = 1'b0;
            tick(s, 1'b0);
            chk({1'b0, cnt_o}, {1'b0, m_cnt});
            $display("test timer source %0d done", s);
        end
        chk({16'h0, oe_o}, 17'h1);
        cfg.timer_src = MTA_SRC_F1;
        cfg.gate_en = 1'b1;
        cfg.gate_level = 1'b1;
        start = 1'b1;
        cyc(4);
        for (int i = 0; i < 3; i++) tick(0, 1'b0);
        g = 1'b1;
        cyc(4);
        for (int i = 0; i < 6; i++) tick(0, 1'b1);
        chk({1'b0, cnt_o}, {1'b0, m_cnt});
        g = 1'b0;
        $display("test gate done");
        cfg = '0;
        pin_e = 1'b0;
        cfg.mode = MTA_MODE_EVENT;
        cfg.pulse_en = 1'b1;
        cfg.edge_rising = 1'b1;
        cfg.dir_up = 1'b1;
        for (int s = 0; s < 3; s++) begin
            start = 1'b0;
            cfg.event_src = 2'(s);
            cyc(4);
            load(16'hfffd);
            start = 1'b1;
            for (int i = 0; i < 7; i++) ev(s, 1'b1, 1'b0);
            $display("test event source %0d done", s);
        end
        start = 1'b0;
        cfg.event_src = MTA_EVT_B2;
        cfg.dir_ext = 1'b1;
        cfg.free_run = 1'b1;
        dd = 1'b1;
        cyc(5);
        load(16'h0001);
        start = 1'b1;
        chk({16'h0, oe_o}, 17'h0);
        for (int i = 0; i < 4; i++) ev(1, 1'b0, 1'b1);
        d = 1'b1;
        cyc(5);
        for (int i = 0; i < 3; i++) ev(1, 1'b1, 1'b1);
        cyc(5);
        chk({1'b0, cnt_o}, {1'b0, m_cnt});
        chk(17'(q.size()), 17'h0);
        $display("test free run done");
        final_report();
    end
endmodule
`default_nettype wire
